// ### o2cfg_params.svh
// Offsets, field positions, reset values and field codes of the output 2 configuration registers
`ifndef O2CFG_PARAMS_SVH
`define O2CFG_PARAMS_SVH

// ==========================================================
// Register offsets and reset values
`define O2CFG_ADDR_CFG_A     8'h6c
`define O2CFG_ADDR_CFG_B     8'h6d
`define O2CFG_RESET_CFG_A    8'h20
`define O2CFG_RESET_CFG_B    8'h20

// ==========================================================
// Field positions (shared layout of both registers)
`define O2CFG_DRIVE_MSB      7
`define O2CFG_DRIVE_LSB      6
`define O2CFG_LEVEL_MSB      5
`define O2CFG_LEVEL_LSB      3
`define O2CFG_IMP_BIT        2
`define O2CFG_BIT1           1
`define O2CFG_BIT0           0

// ==========================================================
// Field codes
`define O2CFG_LEVEL_24DB     3'h0
`define O2CFG_LEVEL_18DB     3'h1
`define O2CFG_LEVEL_M12DB    3'h6
`define O2CFG_LEVEL_RSVD     3'h7
`define O2CFG_LEVEL_RESET    3'h4
`define O2CFG_DRIVE_RESET    2'h0

`endif

// ### o2cfg_pkg.sv
// Types for the output 2 configuration register block
`default_nettype none
package o2cfg_pkg;

  typedef enum logic [1:0] {
    O2CFG_DRIVE_LINE  = 2'h0,
    O2CFG_DRIVE_HP    = 2'h1,
    O2CFG_DRIVE_4OHM  = 2'h2,
    O2CFG_DRIVE_RCV   = 2'h3
  } o2cfg_drive_t;

  typedef enum logic [1:0] {
    O2CFG_ST_IDLE  = 2'b00,
    O2CFG_ST_READ  = 2'b01
  } o2cfg_state_t;

endpackage
`default_nettype wire

// ### o2cfg_field_decode.sv
// Decoder splitting one configuration byte into its shared fields
`timescale 1ns/1ps
`default_nettype none
`include "o2cfg_params.svh"

module o2cfg_field_decode (
  input  wire logic [7:0]             cfg,
  output o2cfg_pkg::o2cfg_drive_t     drive_type,
  output logic [2:0]                  level,
  output logic                        imp_sel,
  output logic                        bit1,
  output logic                        bit0
);

  // ==========================================================
  // Field split
  assign drive_type = o2cfg_pkg::o2cfg_drive_t'(cfg[`O2CFG_DRIVE_MSB:`O2CFG_DRIVE_LSB]);
  assign level      = cfg[`O2CFG_LEVEL_MSB:`O2CFG_LEVEL_LSB];
  assign imp_sel    = cfg[`O2CFG_IMP_BIT];
  assign bit1       = cfg[`O2CFG_BIT1];
  assign bit0       = cfg[`O2CFG_BIT0];

endmodule
`default_nettype wire

// ### o2cfg_regs.sv
// Output 2 channel configuration registers with decoded analog control outputs
//
// Functional notes
// - Register A at 0x6c, 8-bit read/write, resets to 0x20.
// - Register B at 0x6d, 8-bit read/write, resets to 0x20.
// - A bits 7-6: positive output drive type, reset 00.
// - B bits 7-6: negative output drive type, same codes, reset 00.
// - A bits 5-3: positive output level, 24 dB down to -12 dB, reset 100.
// - B bits 5-3: negative output level, same codes, reset 100.
// - A bit 2: negative bypass input impedance, 4.4k or 20k, reset 0.
// - B bit 2: positive bypass input impedance, 4.4k or 20k, reset 0.
// - A bit 1: bypass input differential or single-ended, reset 0.
// - A bit 0: converter 2 bandwidth, 24 kHz or 96 kHz, reset 0.
// - B bit 1: converter 2 full scale, 2 or 4 Vrms, reset 0.
// - B bit 0: converter 2 common-mode tolerance, reset 0.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "o2cfg_params.svh"

module o2cfg_regs (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  output o2cfg_pkg::o2cfg_drive_t     pos_out_drive_type,
  output o2cfg_pkg::o2cfg_drive_t     neg_out_drive_type,
  output logic      [2:0]             pos_out_level,
  output logic      [2:0]             neg_out_level,
  output logic                        neg_bypass_input_impedance,
  output logic                        pos_bypass_input_impedance,
  output logic                        bypass_input_config,
  output logic                        conv2_bandwidth_select,
  output logic                        conv2_fullscale_select,
  output logic                        conv2_common_mode_tolerance,
  output logic                        level_code_reserved,
  output logic                        fullscale_bw_conflict
);

  // ==========================================================
  // State
  // One flop bank; the read answer is registered so the bus sees it one cycle late
  typedef struct packed {
    logic [7:0]               cfg_a;
    logic [7:0]               cfg_b;
    logic [7:0]               rdata;
    o2cfg_pkg::o2cfg_state_t  st;
  } o2cfg_regs_state_t;

  o2cfg_regs_state_t r;
  o2cfg_regs_state_t next_r;

  // Unmapped offsets read as zero rather than aliasing a register
  function automatic logic [7:0] o2cfg_read_mux(input logic [7:0] addr,
                                                input logic [7:0] a,
                                                input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    if (addr == `O2CFG_ADDR_CFG_A) begin
      v = a;
    end else if (addr == `O2CFG_ADDR_CFG_B) begin
      v = b;
    end
    return v;
  endfunction

  // ==========================================================
  // Address decode
  logic wr_a;
  logic wr_b;

  // Exact byte compare: neighbouring registers share the bus and must not alias
  assign wr_a = reg_wr && (reg_addr == `O2CFG_ADDR_CFG_A);
  assign wr_b = reg_wr && (reg_addr == `O2CFG_ADDR_CFG_B);

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.rdata = 8'h00;
    case (r.st)
      o2cfg_pkg::O2CFG_ST_IDLE: begin
        if (reg_rd) begin
          next_r.st = o2cfg_pkg::O2CFG_ST_READ;
        end
      end
      o2cfg_pkg::O2CFG_ST_READ: begin
        // Back-to-back reads keep the answer slot open
        if (!reg_rd) begin
          next_r.st = o2cfg_pkg::O2CFG_ST_IDLE;
        end
      end
      default: begin
        next_r.st = o2cfg_pkg::O2CFG_ST_IDLE;
      end
    endcase
    // Writes land at the edge that samples the strobe
    if (wr_a) begin
      next_r.cfg_a = reg_wdata;
    end
    if (wr_b) begin
      next_r.cfg_b = reg_wdata;
    end
    // All eight bits stored as written, reserved codes included, so reads never lie
    if (reg_rd) begin
      next_r.rdata = o2cfg_read_mux(reg_addr, r.cfg_a, r.cfg_b);
    end
    // Reset is applied last so that it beats a write in the same cycle
    if (sys_rst) begin
      next_r.cfg_a = `O2CFG_RESET_CFG_A;
      next_r.cfg_b = `O2CFG_RESET_CFG_B;
      next_r.rdata = 8'h00;
      next_r.st    = o2cfg_pkg::O2CFG_ST_IDLE;
    end
  end

  // Synchronous reset lives in the next-state logic, so no reset branch here
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // Data is zero outside the cycle after a read
  assign reg_rdata = r.rdata;

  // ==========================================================
  // Field decode
  // Decoder outputs, renamed below to their analog destinations
  logic imp_a;
  logic imp_b;
  logic a_bit1;
  logic a_bit0;
  logic b_bit1;
  logic b_bit0;

  // Both bytes share one layout, so one decoder serves each
  o2cfg_field_decode u_dec_a (
    .cfg        (r.cfg_a),
    .drive_type (pos_out_drive_type),
    .level      (pos_out_level),
    .imp_sel    (imp_a),
    .bit1       (a_bit1),
    .bit0       (a_bit0)
  );

  o2cfg_field_decode u_dec_b (
    .cfg        (r.cfg_b),
    .drive_type (neg_out_drive_type),
    .level      (neg_out_level),
    .imp_sel    (imp_b),
    .bit1       (b_bit1),
    .bit0       (b_bit0)
  );

  assign neg_bypass_input_impedance  = imp_a;
  assign bypass_input_config         = a_bit1;
  assign conv2_bandwidth_select      = a_bit0;
  assign pos_bypass_input_impedance  = imp_b;
  assign conv2_fullscale_select      = b_bit1;
  assign conv2_common_mode_tolerance = b_bit0;

  // Status only: the block does not override software, the analog side decides
  assign level_code_reserved   = (pos_out_level == `O2CFG_LEVEL_RSVD) ||
                                 (neg_out_level == `O2CFG_LEVEL_RSVD);
  assign fullscale_bw_conflict = b_bit1 && a_bit0;

  // ==========================================================
  // Assertions: reset values
  // Reset is synchronous, so the values show one edge after the reset sample
  AST_RESET_A: assert property (@(posedge clk) sys_rst |=> r.cfg_a == 8'h20)
    else $error("Register A reset value wrong");

  AST_RESET_B: assert property (@(posedge clk) sys_rst |=> r.cfg_b == 8'h20)
    else $error("Register B reset value wrong");

  AST_RESET_LEVEL: assert property (@(posedge clk) sys_rst |=>
      pos_out_level == 3'h4 && neg_out_level == 3'h4 && !conv2_fullscale_select)
    else $error("Level reset wrong");

  AST_RESET_DRIVE: assert property (@(posedge clk) sys_rst |=>
      pos_out_drive_type == o2cfg_pkg::O2CFG_DRIVE_LINE && neg_out_drive_type == o2cfg_pkg::O2CFG_DRIVE_LINE)
    else $error("Drive type reset wrong");

  AST_RESET_BITS: assert property (@(posedge clk) sys_rst |=>
      !neg_bypass_input_impedance && !pos_bypass_input_impedance && !bypass_input_config &&
      !conv2_bandwidth_select && !conv2_common_mode_tolerance)
    else $error("Single-bit field reset wrong");

  AST_RESET_RDATA: assert property (@(posedge clk) sys_rst |=>
      reg_rdata == 8'h00 && r.st == o2cfg_pkg::O2CFG_ST_IDLE)
    else $error("Read answer not cleared by reset");

  // ==========================================================
  // Assertions: writes and storage
  AST_WRITE_A: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6c |=> r.cfg_a == $past(reg_wdata))
    else $error("Register A write not stored");

  AST_WRITE_B: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d |=> r.cfg_b == $past(reg_wdata))
    else $error("Register B write not stored");

  AST_POS_FIELDS: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6c |=>
      pos_out_drive_type == $past(reg_wdata[7:6]) && pos_out_level == $past(reg_wdata[5:3]) &&
      neg_bypass_input_impedance == $past(reg_wdata[2]) && bypass_input_config == $past(reg_wdata[1]) &&
      conv2_bandwidth_select == $past(reg_wdata[0]))
    else $error("Register A fields not decoded");

  AST_NEG_FIELDS: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d |=>
      neg_out_drive_type == $past(reg_wdata[7:6]) && neg_out_level == $past(reg_wdata[5:3]) &&
      pos_bypass_input_impedance == $past(reg_wdata[2]) && conv2_fullscale_select == $past(reg_wdata[1]) &&
      conv2_common_mode_tolerance == $past(reg_wdata[0]))
    else $error("Register B fields not decoded");

  // Storage changes only on a write to its own offset
  AST_HOLD_A: assert property (@(posedge clk) disable iff (sys_rst)
      !(reg_wr && reg_addr == 8'h6c) |=> $stable(r.cfg_a))
    else $error("Register A changed without write");

  AST_HOLD_B: assert property (@(posedge clk) disable iff (sys_rst)
      !(reg_wr && reg_addr == 8'h6d) |=> $stable(r.cfg_b))
    else $error("Register B changed without write");

  AST_NO_CROSS_A: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6c |=> $stable(r.cfg_b))
    else $error("Write to A disturbed register B");

  AST_NO_CROSS_B: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d |=> $stable(r.cfg_a))
    else $error("Write to B disturbed register A");

  // Neighbouring offsets must neither store nor disturb
  AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr != 8'h6c && reg_addr != 8'h6d |=> $stable(r.cfg_a) && $stable(r.cfg_b))
    else $error("Unmapped write changed a register");

  // ==========================================================
  // Assertions: reads
  // The answer stands for exactly one cycle; outside it the bus reads zero
  AST_READ_A: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == 8'h6c |=> reg_rdata == $past(r.cfg_a))
    else $error("Register A read wrong");

  AST_READ_B: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == 8'h6d |=> reg_rdata == $past(r.cfg_b))
    else $error("Register B read wrong");

  AST_READBACK: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d ##1 reg_rd && reg_addr == 8'h6d
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Register B readback mismatch");

  AST_READBACK_A: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6c ##1 reg_rd && reg_addr == 8'h6c
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Register A readback mismatch");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr != 8'h6c && reg_addr != 8'h6d |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");

  AST_READ_SLOT: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd |=> r.st == o2cfg_pkg::O2CFG_ST_READ)
    else $error("Read answer slot not opened");

  AST_ANSWER_SLOT: assert property (@(posedge clk) disable iff (sys_rst)
      r.st == o2cfg_pkg::O2CFG_ST_IDLE |-> reg_rdata == 8'h00)
    else $error("Read data outside answer slot");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data held too long");

  // ==========================================================
  // Assertions: software misuse flags
  // Flags only report misuse; storage is never altered by them
  AST_RSVD_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && (reg_addr == 8'h6c || reg_addr == 8'h6d) && reg_wdata[5:3] == 3'h7 |=> level_code_reserved)
    else $error("Reserved level code not flagged");

  AST_RSVD_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6c && reg_wdata[5:3] != 3'h7 && neg_out_level != 3'h7
      |=> !level_code_reserved)
    else $error("Reserved level flag stuck");

  AST_CONFLICT_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d && reg_wdata[1] && conv2_bandwidth_select
      |=> fullscale_bw_conflict)
    else $error("Full scale and bandwidth conflict not flagged");

  AST_CONFLICT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h6d && !reg_wdata[1] |=> !fullscale_bw_conflict)
    else $error("Conflict flag stuck");

  // ==========================================================
  // Coverage of the main scenarios
  COV_WRITE_A: cover property (@(posedge clk) reg_wr && reg_addr == 8'h6c);
  COV_READ_B: cover property (@(posedge clk) reg_rd && reg_addr == 8'h6d);
  COV_B2B: cover property (@(posedge clk) reg_wr ##1 reg_rd);
  COV_RSVD: cover property (@(posedge clk) level_code_reserved);
  COV_CONFLICT: cover property (@(posedge clk) fullscale_bw_conflict);

endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the output 2 configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "o2cfg_params.svh"

module testbench;
  logic                    clk;
  logic                    sys_rst;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  o2cfg_pkg::o2cfg_drive_t pdrv;
  o2cfg_pkg::o2cfg_drive_t ndrv;
  logic [2:0]              plvl;
  logic [2:0]              nlvl;
  logic                    nimp, pimp, bcfg, bw, fs, cmt, rsv, conf;
  int                      n_mismatch;
  int                      n_tests;
  logic [7:0]              v;
  // Rows: byte A, byte B, reserved flag, conflict flag
  logic [17:0]             rows [8] = '{{8'h00, 8'hff, 2'b10}, {8'h4f, 8'h01, 2'b00}, {8'h92, 8'h5a, 2'b00},
                                        {8'hdd, 8'h86, 2'b01}, {8'h25, 8'hcb, 2'b01}, {8'h2e, 8'h14, 2'b00},
                                        {8'h33, 8'h6a, 2'b01}, {8'hb8, 8'h3d, 2'b10}};

  o2cfg_regs u_o2cfg_regs (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_out_drive_type(pdrv),
    .neg_out_drive_type(ndrv), .pos_out_level(plvl), .neg_out_level(nlvl), .neg_bypass_input_impedance(nimp),
    .pos_bypass_input_impedance(pimp), .bypass_input_config(bcfg), .conv2_bandwidth_select(bw),
    .conv2_fullscale_select(fs), .conv2_common_mode_tolerance(cmt), .level_code_reserved(rsv),
    .fullscale_bw_conflict(conf));

  // ==========================================================
  // Clock, watchdog and verdict
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run needs well under 400 cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Bus tasks and comparisons
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, then return to zero
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(negedge clk);
    chk("rdata idle", 8'h00, reg_rdata);
  endtask

  // Write, then read the same offset in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("back to back read", d, reg_rdata);
  endtask

  task automatic chk_regs(input logic [7:0] a, input logic [7:0] b);
    @(negedge clk);
    chk("cfg_a fields", a, {pdrv, plvl, nimp, bcfg, bw});
    chk("cfg_b fields", b, {ndrv, nlvl, pimp, fs, cmt});
    rd(`O2CFG_ADDR_CFG_A, v);
    chk("read cfg_a", a, v);
    rd(`O2CFG_ADDR_CFG_B, v);
    chk("read cfg_b", b, v);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk_regs(`O2CFG_RESET_CFG_A, `O2CFG_RESET_CFG_B);
    // Every drive code on both registers and every level code on register A, reserved code included on both
    foreach (rows[i]) begin
      wr(`O2CFG_ADDR_CFG_A, rows[i][17:10]);
      wr(`O2CFG_ADDR_CFG_B, rows[i][9:2]);
      chk_regs(rows[i][17:10], rows[i][9:2]);
      chk("reserved flag", {7'h00, rows[i][1]}, {7'h00, rsv});
      chk("conflict flag", {7'h00, rows[i][0]}, {7'h00, conf});
    end
    // Neighbouring offsets must neither store nor disturb
    wr(8'h6b, 8'hff);
    wr(8'h6e, 8'hff);
    rd(8'h6b, v);
    chk("read unmapped", 8'h00, v);
    chk_regs(8'hb8, 8'h3d);
    // Read in the very next cycle after a write, on both registers
    wr_rd(`O2CFG_ADDR_CFG_A, 8'h5b);
    wr_rd(`O2CFG_ADDR_CFG_B, 8'ha6);
    // Reset beats a coinciding write
    @(posedge clk);
    sys_rst <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= `O2CFG_ADDR_CFG_B;
    reg_wdata <= 8'hc3;
    @(posedge clk);
    sys_rst <= 1'b0;
    reg_wr <= 1'b0;
    chk_regs(`O2CFG_RESET_CFG_A, `O2CFG_RESET_CFG_B);
    print_verdict();
  end
endmodule
`default_nettype wire
